// [hdl/carrier_wakeup_detector.v]
// Carrier header wakeup detector and standby control
`include "carrier_wakeup_map.vh"
module carrier_wakeup_detector #(
  parameter TICK_DIV      = `TICK_DIV,
  parameter CARRIER_TICKS = `CARRIER_TICKS,
  parameter BOOST_TICKS   = `BOOST_TICKS
) (
  input  wire clk_sys_in,
  input  wire reset_in,
  input  wire standby_in,
  input  wire sliced_data_in,
  output reg  carrier_wake_n_out,
  output reg  receiver_enable_out,
  output reg  gain_boost_out,
  output wire standby_pullup_out
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_HUNT = 3'h1;
  localparam [2:0] ST_WAKE = 3'h2;
  localparam [2:0] ST_DATA = 3'h4;

  reg [2:0]  state_reg;
  reg [7:0]  carrier_count_reg;
  reg [15:0] boost_count_reg;
  reg        standby_prev_reg;
  wire       tick;

  assign standby_pullup_out = 1'b1; // RULE_08

  // ----------------------------------------
  // Tick divider, held clear in standby
  // ----------------------------------------
  tick_divider #(
    .DIVISOR(TICK_DIV)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .reset_in  (reset_in),
    .clear_in  (standby_in),
    .tick_out  (tick)
  );

  // ----------------------------------------
  // Carrier header detection
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (reset_in || standby_in) begin
      state_reg          <= ST_HUNT; // RULE_11
      carrier_count_reg  <= 8'h00; // RULE_11
      carrier_wake_n_out <= 1'b1; // RULE_05
    end else begin
      case (state_reg)
        ST_HUNT: begin
          if (!sliced_data_in) begin
            carrier_count_reg <= 8'h00; // RULE_03
          end else if (tick) begin
            if (carrier_count_reg == CARRIER_TICKS - 1) begin
              carrier_count_reg  <= 8'h00;
              carrier_wake_n_out <= 1'b0; // RULE_01
              state_reg          <= ST_WAKE;
            end else begin
              carrier_count_reg <= carrier_count_reg + 8'h01; // RULE_03
            end
          end
        end
        ST_WAKE: begin
          if (!sliced_data_in) begin
            carrier_wake_n_out <= 1'b1; // RULE_04
            state_reg          <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (!sliced_data_in) begin
            carrier_count_reg <= 8'h00;
          end
          state_reg <= ST_HUNT;
        end
        default: begin
          state_reg          <= ST_HUNT;
          carrier_wake_n_out <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Standby and gain boost after release
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      standby_prev_reg    <= 1'b1;
      receiver_enable_out <= 1'b0;
      gain_boost_out      <= 1'b0;
      boost_count_reg     <= 16'h0000;
    end else begin
      standby_prev_reg    <= standby_in;
      receiver_enable_out <= !standby_in; // RULE_07
      if (standby_in) begin
        gain_boost_out  <= 1'b0;
        boost_count_reg <= 16'h0000;
      end else if (standby_prev_reg) begin
        gain_boost_out  <= 1'b1; // RULE_09
        boost_count_reg <= 16'h0000;
      end else if (gain_boost_out && tick) begin
        if (boost_count_reg == BOOST_TICKS - 1) begin
          gain_boost_out <= 1'b0; // RULE_10
        end else begin
          boost_count_reg <= boost_count_reg + 16'h0001; // RULE_10
        end
      end
    end
  end
endmodule // carrier_wakeup_detector

// [hdl/tick_divider.v]
// Divider making a one-cycle tick enable from the system clock
module tick_divider #(
  parameter DIVISOR = 7272
) (
  input  wire clk_sys_in,
  input  wire reset_in,
  input  wire clear_in,
  output reg  tick_out
);
  reg [15:0] count_reg;

  always @(posedge clk_sys_in) begin
    if (reset_in || clear_in) begin
      count_reg <= 16'h0000;
      tick_out  <= 1'b0;
    end else if (count_reg == DIVISOR - 1) begin
      count_reg <= 16'h0000;
      tick_out  <= 1'b1; // RULE_02
    end else begin
      count_reg <= count_reg + 16'h0001;
      tick_out  <= 1'b0;
    end
  end
endmodule // tick_divider

// [inc/carrier_wakeup_map.vh]
// Constants for the carrier wakeup detector
// Notes on behaviour
// [RULE_01] Wake output is active low on carrier
// [RULE_02] Counter runs on tick from reference oscillator
// [RULE_03] Wake after 128 unbroken carrier ticks
// [RULE_04] Wake held low until data modulation starts
// [RULE_05] Wake detection inactive during shutdown
// [RULE_06] Sender leads each word with long carrier
// [RULE_07] Standby high means shutdown, low means run
// [RULE_08] Standby input weakly pulled high internally
// [RULE_09] Gain currents boosted about 10 ms after standby
// [RULE_10] Boost period counted from reference oscillator
// [RULE_11] Standby clears counter and parks wake high
`ifndef CARRIER_WAKEUP_MAP_VH
`define CARRIER_WAKEUP_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_SYS_HZ           200000000
`define TICK_HZ              27500
`define TICK_DIV             (`CLK_SYS_HZ / `TICK_HZ)
`define CARRIER_TICKS        128
`define BOOST_TIME_US        9700
`define BOOST_REF_KHZ        6750
`define BOOST_TICKS          ((`BOOST_TIME_US * `BOOST_REF_KHZ) / (1000 * 256))
`define BOOST_GAIN_X         45
`endif

// [tb/carrier_wakeup_checks_assertions.sv]
// Checker for the carrier wakeup detector ports
module carrier_wakeup_checks (
  input wire clk_sys_in,
  input wire reset_in,
  input wire standby_in,
  input wire sliced_data_in,
  input wire carrier_wake_n_out,
  input wire receiver_enable_out,
  input wire gain_boost_out,
  input wire standby_pullup_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_wake_parks_high: assert property (standby_in |=> carrier_wake_n_out) else $error("wake low in standby");
  a_standby_stops: assert property (standby_in |=> !receiver_enable_out) else $error("enabled in standby");
  a_wake_on_carrier: assert property ($fell(carrier_wake_n_out) |-> $past(sliced_data_in, 16)) else $error("early wake");
  a_wake_releases: assert property (!carrier_wake_n_out && !sliced_data_in |=> carrier_wake_n_out) else $error("no release");
  a_wake_holds: assert property (!carrier_wake_n_out && sliced_data_in && !standby_in |=> !carrier_wake_n_out) else $error("wake dropped");
  a_boost_starts: assert property ($fell(standby_in) |=> gain_boost_out) else $error("no boost");
  a_boost_off_shut: assert property (standby_in |=> !gain_boost_out) else $error("boost in standby");
  a_pullup_on: assert property (standby_pullup_out) else $error("pullup off");
endmodule // carrier_wakeup_checks
bind carrier_wakeup_detector carrier_wakeup_checks carrier_wakeup_checks_inst (.*);

// [tb/tb_carrier_wakeup_detector.sv]
// Testbench for the carrier wakeup detector
module tb_carrier_wakeup_detector;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, reset_in = 1, run_req = 0, sliced_data_in = 0;
  wire  standby_in, carrier_wake_n_out, receiver_enable_out, gain_boost_out, standby_pullup_out;
  int   fails = 0, checks_done = 0, n;
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  carrier_wakeup_detector #(.TICK_DIV(8), .CARRIER_TICKS(4), .BOOST_TICKS(3)) carrier_wakeup_detector_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .standby_in(standby_in), .sliced_data_in(sliced_data_in),
    .carrier_wake_n_out(carrier_wake_n_out), .receiver_enable_out(receiver_enable_out),
    .gain_boost_out(gain_boost_out), .standby_pullup_out(standby_pullup_out));
  wake_listener wake_listener_inst (.run_req(run_req), .wake_n(carrier_wake_n_out), .standby_line(standby_in));
  task automatic chk(string what, logic seen, logic exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk_sys_in);
  endtask
  task automatic wait_wake;
    n = 0;
    while (carrier_wake_n_out !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic test_release;
    chk("idle_wake", carrier_wake_n_out, 1);
    chk("idle_enable", receiver_enable_out, 0);
    chk("pullup", standby_pullup_out, 1);
    run_req = 1;
    cyc(2);
    chk("enable", receiver_enable_out, 1);
    chk("boost_on", gain_boost_out, 1);
    cyc(22);
    chk("boost_hold", gain_boost_out, 1);
    cyc(1);
    chk("boost_off", gain_boost_out, 0);
    $display("test_release done");
  endtask
  task automatic test_carrier;
    sliced_data_in = 1;
    cyc(16);
    sliced_data_in = 0;
    cyc(1);
    sliced_data_in = 1;
    cyc(16);
    chk("broken_carrier", carrier_wake_n_out, 1);
    sliced_data_in = 0;
    cyc(1);
    sliced_data_in = 1;
    wait_wake();
    chk("wake_late", n >= 16, 1);
    cyc(5);
    chk("wake_held", carrier_wake_n_out, 0);
    sliced_data_in = 0;
    cyc(1);
    chk("wake_release", carrier_wake_n_out, 1);
    chk("one_wake", wake_listener_inst.wakes == 1, 1);
    $display("test_carrier done");
  endtask
  task automatic test_shutdown;
    sliced_data_in = 1;
    run_req = 0;
    cyc(60);
    chk("shut_wake", carrier_wake_n_out, 1);
    chk("shut_enable", receiver_enable_out, 0);
    run_req = 1;
    wait_wake();
    chk("restart_count", n >= 16, 1);
    sliced_data_in = 0;
    cyc(2);
    $display("test_shutdown done");
  endtask
  initial begin
    cyc(2);
    reset_in = 0;
    test_release();
    test_carrier();
    test_shutdown();
    end_of_test();
  end
  initial begin
    #4000;
    fails++;
    end_of_test();
  end
endmodule // tb_carrier_wakeup_detector

// [tb/wake_listener.sv]
// Decoder model that drives standby and counts wake events
module wake_listener (
  input  wire logic run_req,
  input  wire logic wake_n,
  output wire logic standby_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int wakes = 0;
  assign standby_line = run_req ? 1'b0 : 1'b1;
  always @(negedge wake_n) wakes++;
endmodule // wake_listener
